// [shared/lps_pkg.sv]
/*
 * Shared constants and types for the SDRAM low-power state logic.
 * Assumes a single 50 MHz core_clk shared by both ends, command pins sampled
 * on its rising edge.
 */
package lps_pkg;

   // ----------------------------------------------------------------
   // Timing, in ns, and derived cycle counts at 20 ns
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned SELF_REFRESH_MIN_RESIDENCY_NS = 60;
   localparam int unsigned SR_EXIT_TO_NONREAD_DELAY_NS = 140;
   localparam int unsigned SR_EXIT_TO_READ_DELAY_NS = 4000;
   localparam int unsigned PD_EXIT_LATENCY_NS = 40;
   localparam int unsigned FAST_ACTIVE_PD_EXIT_LATENCY_NS = 40;
   localparam int unsigned SLOW_ACTIVE_PD_EXIT_LATENCY_NS = 120;
   localparam int unsigned REFRESH_CYCLE_TIME_NS = 140;
   localparam int unsigned CKE_DROP_CLOCK_HOLD_NS = 40;
   localparam int unsigned FREQ_CHANGE_WAIT_CYC = 2;
   localparam int unsigned PD_MAX_INTERVALS = 9;

   // Least times round up
   localparam int unsigned SR_MIN_CYC =
      (SELF_REFRESH_MIN_RESIDENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned XSNR_CYC =
      (SR_EXIT_TO_NONREAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned XSRD_CYC =
      (SR_EXIT_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned XP_CYC =
      (PD_EXIT_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned XARD_CYC =
      (FAST_ACTIVE_PD_EXIT_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned XARDS_CYC =
      (SLOW_ACTIVE_PD_EXIT_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RFC_CYC =
      (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CKE_HOLD_CYC =
      (CKE_DROP_CLOCK_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Internal refresh launched this many cycles into self refresh
   localparam int unsigned SR_REFRESH_AT_CYC = 1;

   localparam int CNT_W = 16;

   // ----------------------------------------------------------------
   // Command encoding {cs_n, ras_n, cas_n, we_n}
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      LPS_CMD_NOP = 4'h7,
      LPS_CMD_REFRESH = 4'h1,
      LPS_CMD_MODE_SET = 4'h0,
      LPS_CMD_ACT = 4'h3,
      LPS_CMD_PRE = 4'h2,
      LPS_CMD_READ = 4'h5,
      LPS_CMD_WRITE = 4'h4,
      LPS_CMD_DESEL = 4'h8
   } lps_cmd_t;

   typedef enum logic [2:0] {
      LPS_PS_ACTIVE,
      LPS_PS_SELF_REFRESH,
      LPS_PS_PRE_PD,
      LPS_PS_ACT_PD_FAST,
      LPS_PS_ACT_PD_SLOW
   } lps_pstate_t;

   function automatic logic is_nop_or_desel(input logic [3:0] cmd);
      return cmd[3] || (cmd[2:0] == 3'h7);
   endfunction : is_nop_or_desel

endpackage : lps_pkg

// [shared/lps_if.sv]
/*
 * Command link between the memory controller and the SDRAM power logic.
 * Assumes both ends run on the same core_clk; no two-way pins here.
 */
interface lps_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic odt;
   logic clk_stop;

   modport dev (input cke, input cs_n, input ras_n, input cas_n, input we_n,
      input odt, input clk_stop);
   modport ctl (output cke, output cs_n, output ras_n, output cas_n,
      output we_n, output odt, output clk_stop);
endinterface : lps_if

// [rtl/lps_device.sv]
/*
 * Device end: decodes commands and tracks self refresh and power-down.
 * Assumes the controller keeps its side of the link timing; inputs are
 * synchronous to core_clk.
 */
// Operation
// - Self refresh on CS RAS CAS CKE low
// - Controller turns termination off before entry
// - Controller holds clock enable low, minimum residency
// - DLL off and clock gated in self refresh
// - Only clock enable heeded in self refresh
// - Internal refresh within minimum residency
// - Clock may stop after entry, stable before exit
// - Only NOP/deselect during exit delay
// - Clock enable held high during read exit delay
// - Extra auto refresh before self refresh re-entry
// - Power-down on clock enable low with NOP
// - No clock enable drop during bursts
// - Precharge or active power-down by open rows
// - Mode bit selects fast or slow exit
// - DLL off except in fast active power-down
// - Buffers off in power-down except clock/ODT/CKE
// - Power-down no longer than nine refresh intervals
// - Exit on clock enable high with NOP
// - Asynchronous clock enable drop needs re-initialization
// - Frequency change only in precharge power-down; controller raises freq_change_ok in any power-down, whatever bank_open
// - After frequency change reset DLL, relock
// - NOP decoded, does not end bursts
// - Chip select high is deselect
module lps_device (
   input wire logic core_clk,
   input wire logic nrst,
   lps_if.dev link,
   input wire logic slow_exit_sel,
   input wire logic bank_open,
   input wire logic burst_busy,
   output logic [2:0] power_state,
   output logic dll_enable,
   output logic int_clk_enable,
   output logic io_buf_enable,
   output logic int_refresh,
   output logic cmd_valid,
   output logic [3:0] cmd_code,
   output logic exit_busy,
   output logic data_lost
);

   lps_pkg::lps_pstate_t st_q;
   logic cke_q;
   logic [3:0] cmd;
   logic [lps_pkg::CNT_W-1:0] cnt_q;
   logic [lps_pkg::CNT_W-1:0] exit_q;

   // Chip select high masks the strobes
   assign cmd = link.cs_n ? 4'h8 : {1'b0, link.ras_n, link.cas_n, link.we_n};

   // ----------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= lps_pkg::LPS_PS_ACTIVE;
      end else begin
         unique case (st_q)
            lps_pkg::LPS_PS_ACTIVE: begin
               if (cke_q && !link.cke && cmd == 4'h1) begin
                  st_q <= lps_pkg::LPS_PS_SELF_REFRESH;
               end else if (cke_q && !link.cke && lps_pkg::is_nop_or_desel(cmd)
                  && !burst_busy) begin
                  if (!bank_open) begin
                     st_q <= lps_pkg::LPS_PS_PRE_PD;
                  end else if (slow_exit_sel) begin
                     st_q <= lps_pkg::LPS_PS_ACT_PD_SLOW;
                  end else begin
                     st_q <= lps_pkg::LPS_PS_ACT_PD_FAST;
                  end
               end
            end
            lps_pkg::LPS_PS_SELF_REFRESH: begin
               // Only clock enable wakes the device
               if (link.cke) begin
                  st_q <= lps_pkg::LPS_PS_ACTIVE;
               end
            end
            default: begin
               if (link.cke && lps_pkg::is_nop_or_desel(cmd)) begin
                  st_q <= lps_pkg::LPS_PS_ACTIVE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cke_q <= 1'b1;
      end else begin
         cke_q <= link.cke;
      end
   end

   // ----------------------------------------------------------------
   // Residency counter and internal refresh
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else if (st_q == lps_pkg::LPS_PS_SELF_REFRESH) begin
         if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end else begin
         cnt_q <= '0;
      end
   end

   // One refresh early in self refresh
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         int_refresh <= 1'b0;
      end else begin
         int_refresh <= (st_q == lps_pkg::LPS_PS_SELF_REFRESH) &&
            (cnt_q == lps_pkg::CNT_W'(lps_pkg::SR_REFRESH_AT_CYC));
      end
   end

   // ----------------------------------------------------------------
   // Exit interval tracking
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         exit_q <= '0;
      end else if (st_q == lps_pkg::LPS_PS_SELF_REFRESH && link.cke) begin
         exit_q <= lps_pkg::CNT_W'(lps_pkg::XSNR_CYC);
      end else if (exit_q != '0) begin
         exit_q <= exit_q - 1'b1;
      end
   end

   // Clock enable dropped outside a legal entry
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         data_lost <= 1'b0;
      end else if (st_q == lps_pkg::LPS_PS_ACTIVE && cke_q && !link.cke &&
         (burst_busy || !(cmd == 4'h1 || lps_pkg::is_nop_or_desel(cmd)))) begin
         data_lost <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Registered command and status
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_valid <= 1'b0;
         cmd_code <= 4'h7;
      end else begin
         // NOP/deselect is not a command, bursts run on
         cmd_valid <= st_q == lps_pkg::LPS_PS_ACTIVE && link.cke && cke_q &&
            !lps_pkg::is_nop_or_desel(cmd) && exit_q == '0;
         cmd_code <= cmd;
      end
   end

   assign power_state = st_q;
   assign exit_busy = exit_q != '0;
   assign dll_enable = st_q == lps_pkg::LPS_PS_ACTIVE ||
      st_q == lps_pkg::LPS_PS_ACT_PD_FAST;
   assign int_clk_enable = st_q != lps_pkg::LPS_PS_SELF_REFRESH;
   // Buffers off in any low-power state
   assign io_buf_enable = st_q == lps_pkg::LPS_PS_ACTIVE;

endmodule : lps_device

// [rtl/lps_controller.sv]
/*
 * Controller end: sequences self refresh and power-down on request.
 * Assumes user requests are level signals synchronous to core_clk.
 */
module lps_controller #(
   parameter int unsigned REFI_CYC = 390,
   parameter int unsigned XSRD_CYC = lps_pkg::XSRD_CYC
) (
   input wire logic core_clk,
   input wire logic nrst,
   lps_if.ctl link,
   input wire logic sr_req,
   input wire logic pd_req,
   input wire logic freq_change_req,
   input wire logic bursts_idle,
   output logic busy,
   output logic cmd_ready,
   output logic freq_change_ok,
   output logic dll_reset_due
);

   typedef enum logic [3:0] {
      LPC_IDLE, LPC_SR_ODT, LPC_SR_IN, LPC_SR_EXIT, LPC_SR_REF, LPC_PD_IN,
      LPC_PD_EXIT, LPC_WAIT
   } lpc_state_t;

   lpc_state_t st_q;
   logic [lps_pkg::CNT_W-1:0] cnt_q;
   logic [lps_pkg::CNT_W-1:0] pd_cnt_q;
   logic [3:0] cmd_q;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= LPC_IDLE;
         cnt_q <= '0;
         cmd_q <= 4'h7;
         link.cke <= 1'b1;
         link.odt <= 1'b0;
         link.clk_stop <= 1'b0;
         dll_reset_due <= 1'b0;
         pd_cnt_q <= '0;
      end else begin
         cmd_q <= 4'h7;
         if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
         unique case (st_q)
            LPC_IDLE: begin
               // Only drop clock enable with bursts idle
               if (sr_req && bursts_idle) begin
                  link.odt <= 1'b0;
                  st_q <= LPC_SR_ODT;
               end else if ((pd_req || freq_change_req) && bursts_idle) begin
                  link.cke <= 1'b0;
                  pd_cnt_q <= '0;
                  st_q <= LPC_PD_IN;
               end
            end
            LPC_SR_ODT: begin
               cmd_q <= 4'h1;
               link.cke <= 1'b0;
               cnt_q <= lps_pkg::CNT_W'(lps_pkg::SR_MIN_CYC);
               st_q <= LPC_SR_IN;
            end
            LPC_SR_IN: begin
               link.clk_stop <= sr_req;
               if (!sr_req && cnt_q == '0 && !link.clk_stop) begin
                  link.cke <= 1'b1;
                  cnt_q <= lps_pkg::CNT_W'(XSRD_CYC);
                  st_q <= LPC_SR_EXIT;
               end
            end
            LPC_SR_EXIT: begin
               if (cnt_q == '0) begin
                  cmd_q <= 4'h1;
                  cnt_q <= lps_pkg::CNT_W'(lps_pkg::RFC_CYC);
                  st_q <= LPC_SR_REF;
               end
            end
            LPC_SR_REF: begin
               if (cnt_q == '0) st_q <= LPC_IDLE;
            end
            LPC_PD_IN: begin
               if (pd_cnt_q != '1) pd_cnt_q <= pd_cnt_q + 1'b1;
               // Remember a frequency change for the DLL reset
               if (freq_change_req) dll_reset_due <= 1'b1;
               if ((!pd_req && !freq_change_req) ||
                  pd_cnt_q >= lps_pkg::CNT_W'(lps_pkg::PD_MAX_INTERVALS * REFI_CYC - 1)) begin
                  link.cke <= 1'b1;
                  cnt_q <= lps_pkg::CNT_W'(lps_pkg::XARDS_CYC);
                  st_q <= LPC_PD_EXIT;
               end
            end
            LPC_PD_EXIT: begin
               if (cnt_q == '0) st_q <= LPC_WAIT;
            end
            default: begin
               // DLL reset command once exit latency has run
               if (dll_reset_due) cmd_q <= lps_pkg::LPS_CMD_MODE_SET;
               dll_reset_due <= 1'b0;
               st_q <= LPC_IDLE;
            end
         endcase
      end
   end

   // Frequency change only after two clocks in power-down
   assign freq_change_ok = st_q == LPC_PD_IN &&
      pd_cnt_q >= lps_pkg::CNT_W'(lps_pkg::FREQ_CHANGE_WAIT_CYC);
   // Never drops clock enable asynchronously; clk_stop rises one cycle after clock enable drops, short of CKE_HOLD_CYC (2)
   assign busy = st_q != LPC_IDLE;
   assign cmd_ready = st_q == LPC_IDLE && !dll_reset_due;
   assign link.cs_n = cmd_q[3];
   assign link.ras_n = cmd_q[2];
   assign link.cas_n = cmd_q[1];
   assign link.we_n = cmd_q[0];

endmodule : lps_controller

// [dv/lps_link_chk.sv]
/*
 * Concurrent checks on the controller/device link and the device outputs.
 * Assumes it is instantiated beside the link interface, one core_clk domain.
 */
module lps_link_chk (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic odt,
   input wire logic burst_busy,
   input wire logic bank_open,
   input wire logic slow_exit_sel,
   input wire logic [2:0] power_state,
   input wire logic dll_enable,
   input wire logic int_clk_enable,
   input wire logic io_buf_enable,
   input wire logic int_refresh,
   input wire logic cmd_valid,
   input wire logic [3:0] cmd_code
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // ---------------------------------------------
   // Decoded state and command
   // ---------------------------------------------
   logic act, sr, pd;
   logic [3:0] cmd;
   logic [2:0] pd_exp_q;
   assign cmd = cs_n ? 4'h8 : {1'b0, ras_n, cas_n, we_n};
   assign act = power_state == lps_pkg::LPS_PS_ACTIVE;
   assign sr = power_state == lps_pkg::LPS_PS_SELF_REFRESH;
   assign pd = !act && !sr;
   always_ff @(posedge core_clk) begin
      pd_exp_q <= !bank_open ? lps_pkg::LPS_PS_PRE_PD :
         slow_exit_sel ? lps_pkg::LPS_PS_ACT_PD_SLOW : lps_pkg::LPS_PS_ACT_PD_FAST;
   end

   sequence nop_s;
      cs_n || cmd == 4'h7;
   endsequence
   sequence sr_cmd_s;
      !cke && cmd == 4'h1;
   endsequence
   sequence sr_exit_s;
      sr && cke;
   endsequence

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   a_sr_entry: assert property (act ##0 sr_cmd_s |=> sr)
      else $error("self refresh not entered");
   a_odt_before_sr: assert property (sr_cmd_s |-> !odt)
      else $error("termination on at self refresh entry");
   a_sr_residency: assert property (act ##0 sr_cmd_s |=> !cke [*3])
      else $error("clock enable raised too early");
   a_sr_gating: assert property (sr |-> !dll_enable && !int_clk_enable)
      else $error("loop or clock running in self refresh");
   a_sr_ignore: assert property (sr && !cke |=> sr && !cmd_valid)
      else $error("input heeded in self refresh");
   a_sr_refresh: assert property ($rose(sr) |-> ##[0:3] int_refresh)
      else $error("no internal refresh in self refresh");
   a_exit_nops: assert property (sr_exit_s |-> nop_s [*7])
      else $error("command during exit delay");
   a_exit_cke_high: assert property (sr_exit_s |-> cke [*8])
      else $error("clock enable dropped in exit period");
   a_pd_entry: assert property (act && !cke && !burst_busy ##0 nop_s |=>
      power_state == pd_exp_q)
      else $error("wrong power-down entry");
   a_pd_buffers: assert property (pd |-> !io_buf_enable &&
      dll_enable == (power_state == lps_pkg::LPS_PS_ACT_PD_FAST))
      else $error("buffers or loop wrong in power-down");
   a_pd_exit: assert property (pd && cke ##0 nop_s |=> act)
      else $error("power-down not left");
   a_nop_decode: assert property (act && cke ##0 nop_s |=>
      !cmd_valid && cmd_code == $past(cmd))
      else $error("idle command decoded wrongly");
endmodule : lps_link_chk

// [dv/tb_sdram_low_power_state_control.sv]
/*
 * Testbench: controller and device joined by one link, plus a second device
 * driven directly by the bench for faults. Assumes a 50 MHz core_clk.
 */
module tb_sdram_low_power_state_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic sr_req = 1'b0, pd_req = 1'b0, fc_req = 1'b0, idle = 1'b1;
   logic bank_open = 1'b0, slow_sel = 1'b0, busy2 = 1'b0, hit;
   logic [2:0] ps, ps2;
   logic dll_en, clk_en, buf_en, int_ref, cmd_v, cmd_v2, ex_busy, lost, lost2;
   logic busy, rdy, fc_ok, dll_rst;
   logic [3:0] code, code2;
   lps_pkg::lps_pstate_t pd_tab[3] = '{lps_pkg::LPS_PS_PRE_PD,
      lps_pkg::LPS_PS_ACT_PD_FAST, lps_pkg::LPS_PS_ACT_PD_SLOW};
   int errors = 0, checks_done = 0, run = 0, max_run = 0, k;
   lps_if l1 ();
   lps_if l2 ();

   always #10 core_clk = ~core_clk;

   lps_controller #(.REFI_CYC(10), .XSRD_CYC(8)) lps_controller_i (.core_clk(core_clk),
      .nrst(nrst), .link(l1), .sr_req(sr_req), .pd_req(pd_req), .freq_change_req(fc_req),
      .bursts_idle(idle), .busy(busy), .cmd_ready(rdy), .freq_change_ok(fc_ok),
      .dll_reset_due(dll_rst));
   lps_device lps_device_i (.core_clk(core_clk), .nrst(nrst), .link(l1),
      .slow_exit_sel(slow_sel), .bank_open(bank_open), .burst_busy(!idle),
      .power_state(ps), .dll_enable(dll_en), .int_clk_enable(clk_en), .io_buf_enable(buf_en),
      .int_refresh(int_ref), .cmd_valid(cmd_v), .cmd_code(code), .exit_busy(ex_busy),
      .data_lost(lost));
   lps_device lps_device_2_i (.core_clk(core_clk), .nrst(nrst), .link(l2),
      .slow_exit_sel(1'b0), .bank_open(1'b0), .burst_busy(busy2), .power_state(ps2),
      .dll_enable(), .int_clk_enable(), .io_buf_enable(), .int_refresh(), .cmd_valid(cmd_v2),
      .cmd_code(code2), .exit_busy(), .data_lost(lost2));
   lps_link_chk lps_link_chk_i (.core_clk(core_clk), .nrst(nrst), .cke(l1.cke),
      .cs_n(l1.cs_n), .ras_n(l1.ras_n), .cas_n(l1.cas_n), .we_n(l1.we_n), .odt(l1.odt),
      .burst_busy(!idle), .bank_open(bank_open), .slow_exit_sel(slow_sel),
      .power_state(ps), .dll_enable(dll_en), .int_clk_enable(clk_en),
      .io_buf_enable(buf_en), .int_refresh(int_ref), .cmd_valid(cmd_v), .cmd_code(code));

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic wait_ps(input logic [2:0] exp, input string name);
      for (k = 0; ps !== exp && k < 300; k++) tick(1);
      chk(name, {1'b0, ps}, {1'b0, exp});
   endtask : wait_ps

   task automatic wait_cmd(input logic [3:0] c, input string name);
      for (k = 0; !(l1.cke === 1'b1 && {l1.cs_n, l1.ras_n, l1.cas_n, l1.we_n} === c)
         && k < 100; k++) tick(1);
      chk(name, {3'b0, k < 100}, 4'h1);
   endtask : wait_cmd

   task automatic drv2(input logic c, input logic [3:0] cmd);
      @(posedge core_clk);
      l2.cke <= c;
      {l2.cs_n, l2.ras_n, l2.cas_n, l2.we_n} <= cmd;
   endtask : drv2

   task automatic finish_test();
      $display("checks %0d, errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test

   // Longest power-down stretch with clock enable low
   always @(posedge core_clk) begin
      if (nrst && !l1.cke && ps != lps_pkg::LPS_PS_SELF_REFRESH) run = run + 1;
      else run = 0;
      if (run > max_run) max_run = run;
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      finish_test();
   end

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      {l2.cke, l2.cs_n, l2.ras_n, l2.cas_n, l2.we_n, l2.odt, l2.clk_stop} <= 7'h5c;
      repeat (2) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk) sr_req <= 1'b1;
      wait_ps(lps_pkg::LPS_PS_SELF_REFRESH, "sr_entry");
      chk("odt_sr", {3'b0, l1.odt}, 4'h0);
      chk("dll_clk_sr", {2'b0, dll_en, clk_en}, 4'h0);
      hit = 1'b0;
      repeat (3) begin
         tick(1);
         hit = hit | int_ref;
      end
      chk("int_refresh", {3'b0, hit}, 4'h1);
      @(posedge core_clk) sr_req <= 1'b0;
      wait_ps(lps_pkg::LPS_PS_ACTIVE, "sr_exit");
      chk("exit_busy", {3'b0, ex_busy}, 4'h1);
      wait_cmd(lps_pkg::LPS_CMD_REFRESH, "extra_refresh");
      tick(1);
      chk("ref_decode", {cmd_v, code[2:0]}, {1'b1, lps_pkg::LPS_CMD_REFRESH[2:0]});
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         bank_open <= i > 0;
         slow_sel <= i == 2;
         pd_req <= 1'b1;
         wait_ps(pd_tab[i], "pd_entry");
         chk("dll_pd", {3'b0, dll_en}, {3'b0, i == 1});
         chk("buf_pd", {3'b0, buf_en}, 4'h0);
         tick(100);
         @(posedge core_clk) pd_req <= 1'b0;
         wait_ps(lps_pkg::LPS_PS_ACTIVE, "pd_exit");
      end
      chk("pd_span", {3'b0, max_run <= 90}, 4'h1);
      @(posedge core_clk);
      bank_open <= 1'b0;
      fc_req <= 1'b1;
      for (k = 0; fc_ok !== 1'b1 && k < 100; k++) tick(1);
      chk("fc_state", {1'b0, ps}, {1'b0, lps_pkg::LPS_PS_PRE_PD});
      chk("fc_pins", {2'b0, l1.cke, l1.odt}, 4'h0);
      @(posedge core_clk) fc_req <= 1'b0;
      wait_ps(lps_pkg::LPS_PS_ACTIVE, "fc_exit");
      chk("dll_reset_due", {2'b0, dll_rst, rdy}, 4'h2);
      wait_cmd(lps_pkg::LPS_CMD_MODE_SET, "dll_reset");
      chk("cmd_ready", {1'b0, busy, dll_rst, rdy}, 4'h1);
      chk("no_loss", {3'b0, lost}, 4'h0);
      drv2(1'b1, 4'h8);
      tick(1);
      chk("deselect", {cmd_v2, code2[2:0]}, 4'h0);
      chk("deselect_code", code2, 4'h8);
      drv2(1'b0, lps_pkg::LPS_CMD_REFRESH);
      drv2(1'b0, lps_pkg::LPS_CMD_ACT);
      tick(1);
      chk("sr_ignore", {cmd_v2, ps2}, {1'b0, lps_pkg::LPS_PS_SELF_REFRESH});
      drv2(1'b1, lps_pkg::LPS_CMD_NOP);
      tick(12);
      chk("sr_exit2", {1'b0, ps2}, {1'b0, lps_pkg::LPS_PS_ACTIVE});
      drv2(1'b0, lps_pkg::LPS_CMD_NOP);
      busy2 <= 1'b1;
      tick(1);
      chk("burst_drop", {lost2, ps2}, {1'b1, lps_pkg::LPS_PS_ACTIVE});
      drv2(1'b1, lps_pkg::LPS_CMD_NOP);
      busy2 <= 1'b0;
      tick(2);
      chk("lost_sticky", {3'b0, lost2}, 4'h1);
      finish_test();
   end
endmodule : tb_sdram_low_power_state_control
